// File: design/ebsd_pkg.sv
// Purpose: constants and types for the external bus space decoder
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   width codes are shared by global and per-space controls
`default_nettype none
package ebsd_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_GLOBAL  = 8'h00;
   localparam logic [7:0] OFF_SPACE0  = 8'h04;
   localparam logic [7:0] OFF_ROUTE0  = 8'h14;
   localparam logic [7:0] OFF_ROUTE1  = 8'h18;
   localparam logic [7:0] OFF_ROUTE2  = 8'h1C;
   localparam logic [7:0] OFF_BND10   = 8'h20;
   localparam logic [7:0] OFF_BND21   = 8'h24;
   localparam logic [7:0] OFF_BND32   = 8'h28;
   localparam logic [7:0] OFF_KEY     = 8'h2C;
   localparam logic [7:0] OFF_PROTECT = 8'h30;
   localparam logic [7:0] OFF_MODE    = 8'h34;
   localparam logic [7:0] OFF_CLKCTL  = 8'h38;
   localparam logic [7:0] OFF_STATUS  = 8'h3C;
   // ----------------------------------------------------------------
   // field positions and codes
   // ----------------------------------------------------------------
   localparam int        MUX_BIT     = 2;
   localparam int        UNLOCK_BIT  = 1;
   localparam int        MICRO_BIT   = 0;
   localparam int        STROBE_BIT  = 1;
   localparam logic [1:0] W8         = 2'h0;
   localparam logic [1:0] W16        = 2'h1;
   localparam logic [1:0] W32        = 2'h2;
   localparam logic [7:0] KEY_OPEN   = 8'hAA;
   localparam logic [7:0] SPACE3_BASE = 8'h02;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_BND10  = 8'hC0;
   localparam logic [7:0] RST_BND21  = 8'h80;
   localparam logic [7:0] RST_BND32  = 8'h40;
   localparam logic [3:0] RST_ROUTE  = 4'h0;
   typedef enum {ST_IDLE, ST_LAUNCH, ST_ADDR, ST_STROBE, ST_DONE}
      ebsd_state_e;
endpackage : ebsd_pkg
`default_nettype wire

// File: design/ebsd_top.sv
// Purpose: external bus space decoder, APB registers, bus sequencer
// Assumes: boot straps come from logic on CLK; BCLK is asynchronous
// Notes:   sequencer strobes and selects change only on a sampled BCLK rise
`default_nettype none
module ebsd_top (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output var  logic [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // boot straps
   input  wire logic        BOOT_MICRO_MODE,
   input  wire logic [1:0]  BOOT_VECTOR_LSB,
   // cpu bus adapter side
   input  wire logic        CPU_REQ,
   input  wire logic        CPU_WRITE,
   input  wire logic [31:0] CPU_ADDR,
   input  wire logic [63:0] CPU_WDATA,
   output var  logic [63:0] CPU_RDATA,
   output logic             CPU_DONE,
   output var  logic        CPU_MISS,
   // external bus
   input  wire logic        BCLK,
   output logic [23:0]      A_OUT,
   output logic [23:0]      A_OE,
   input  wire logic [15:0] A_IN,
   output logic [31:0]      D_OUT,
   output logic [31:0]      D_OE,
   input  wire logic [31:0] D_IN,
   output logic             RD_N,
   output logic             WR_N,
   output logic             ALE,
   output logic [3:0]       ALT_SEL_OUT,
   output logic [3:0]       ALT_SEL_OE,
   output logic [2:0]       PORT_SEL_OUT,
   output logic [2:0]       PORT_SEL_OE
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [6:0] bits_of(input logic [1:0] w);
      unique case (w)
         ebsd_pkg::W16: bits_of = 7'd16;
         ebsd_pkg::W32: bits_of = 7'd32;
         default:       bits_of = 7'd8;
      endcase
   endfunction : bits_of

   function automatic logic [31:0] mask_of(input logic [1:0] w);
      mask_of = (32'h1 << bits_of(w)) - 32'h1;
      if (w == ebsd_pkg::W32) begin
         mask_of = 32'hFFFFFFFF;
      end
   endfunction : mask_of

   // ----------------------------------------------------------------
   // bus clock sampling
   // ----------------------------------------------------------------
   logic bclk_s1, bclk_s2, bclk_s3;
   logic [31:0] d_s1, d_s2;
   logic [15:0] a_s1, a_s2;
   logic bclk_rise;
   // third stage only feeds the edge compare, never the first
   always_ff @(posedge CLK) begin
      bclk_s1 <= BCLK;
      bclk_s2 <= bclk_s1;
      bclk_s3 <= bclk_s2;
      d_s1    <= D_IN;
      d_s2    <= d_s1;
      a_s1    <= A_IN;
      a_s2    <= a_s1;
   end
   assign bclk_rise = bclk_s2 & ~bclk_s3;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [2:0] gbc, next_gbc;
   logic [2:0] sbc [0:3];
   logic [2:0] next_sbc [0:3];
   logic [3:0] route0, next_route0, route1, next_route1;
   logic [2:0] route2, next_route2;
   logic [7:0] bnd10, next_bnd10, bnd21, next_bnd21;
   logic [7:0] bnd32, next_bnd32, key, next_key;
   logic       unlock, next_unlock, micro, next_micro;
   logic       strobe_style, next_strobe_style;
   logic       clk_set, next_clk_set, strap_done;
   logic [31:0] rd_val;
   logic        hit;
   logic [3:0]  status;
   logic        wr_en;

   assign wr_en   = PSEL & PENABLE & PWRITE;
   assign PREADY  = PENABLE;
   assign PSLVERR = PSEL & PENABLE & ~hit;

   // next register values from apb writes and boot straps
   always_comb begin
      next_gbc          = gbc;
      next_sbc          = sbc;
      next_route0       = route0;
      next_route1       = route1;
      next_route2       = route2;
      next_bnd10        = bnd10;
      next_bnd21        = bnd21;
      next_bnd32        = bnd32;
      next_key          = key;
      next_unlock       = unlock;
      next_micro        = micro;
      next_strobe_style = strobe_style;
      next_clk_set      = clk_set;
      if (!strap_done) begin
         // straps caught once, right after reset release
         next_micro     = BOOT_MICRO_MODE;
         next_gbc[1:0]  = BOOT_VECTOR_LSB;
         for (int i = 0; i < 4; i++) begin
            next_sbc[i][1:0] = BOOT_VECTOR_LSB;
         end
         next_route0[0] = BOOT_MICRO_MODE;
      end else if (wr_en) begin
         unique case (PADDR)
            ebsd_pkg::OFF_GLOBAL: begin
               if (key == ebsd_pkg::KEY_OPEN) begin
                  next_gbc = PWDATA[2:0];
               end
            end
            ebsd_pkg::OFF_ROUTE0:  next_route0 = PWDATA[3:0];
            ebsd_pkg::OFF_ROUTE1:  next_route1 = PWDATA[3:0];
            ebsd_pkg::OFF_ROUTE2: begin
               if (unlock) begin
                  next_route2 = PWDATA[2:0];
               end
            end
            ebsd_pkg::OFF_BND10:   next_bnd10 = PWDATA[7:0];
            ebsd_pkg::OFF_BND21:   next_bnd21 = PWDATA[7:0];
            ebsd_pkg::OFF_BND32:   next_bnd32 = PWDATA[7:0];
            ebsd_pkg::OFF_KEY:     next_key   = PWDATA[7:0];
            ebsd_pkg::OFF_PROTECT: begin
               next_unlock = PWDATA[ebsd_pkg::UNLOCK_BIT];
            end
            ebsd_pkg::OFF_MODE: begin
               next_strobe_style = PWDATA[ebsd_pkg::STROBE_BIT];
            end
            ebsd_pkg::OFF_CLKCTL:  next_clk_set = PWDATA[0];
            default: begin
               for (int i = 0; i < 4; i++) begin
                  if (PADDR == ebsd_pkg::OFF_SPACE0 + 8'(4 * i) &&
                      key == ebsd_pkg::KEY_OPEN) begin
                     next_sbc[i] = PWDATA[2:0];
                  end
               end
            end
         endcase
      end
   end

   // read mux and address decode
   always_comb begin
      rd_val = 32'h0;
      hit    = 1'b1;
      unique case (PADDR)
         ebsd_pkg::OFF_GLOBAL:  rd_val = {29'h0, gbc};
         ebsd_pkg::OFF_ROUTE0:  rd_val = {28'h0, route0};
         ebsd_pkg::OFF_ROUTE1:  rd_val = {28'h0, route1};
         ebsd_pkg::OFF_ROUTE2:  rd_val = {29'h0, route2};
         ebsd_pkg::OFF_BND10:   rd_val = {24'h0, bnd10};
         ebsd_pkg::OFF_BND21:   rd_val = {24'h0, bnd21};
         ebsd_pkg::OFF_BND32:   rd_val = {24'h0, bnd32};
         ebsd_pkg::OFF_KEY:     rd_val = {24'h0, key};
         ebsd_pkg::OFF_PROTECT: rd_val = {30'h0, unlock, 1'b0};
         ebsd_pkg::OFF_MODE:    rd_val = {30'h0, strobe_style, micro};
         ebsd_pkg::OFF_CLKCTL:  rd_val = {31'h0, clk_set};
         ebsd_pkg::OFF_STATUS:  rd_val = {28'h0, status};
         default: begin
            hit = 1'b0;
            for (int i = 0; i < 4; i++) begin
               if (PADDR == ebsd_pkg::OFF_SPACE0 + 8'(4 * i)) begin
                  rd_val = {29'h0, sbc[i]};
                  hit    = 1'b1;
               end
            end
         end
      endcase
   end

   // register state; read data latched in the setup cycle
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         gbc <= 3'h0;
         for (int i = 0; i < 4; i++) begin
            sbc[i] <= 3'h0;
         end
         route0       <= ebsd_pkg::RST_ROUTE;
         route1       <= ebsd_pkg::RST_ROUTE;
         route2       <= 3'h0;
         bnd10        <= ebsd_pkg::RST_BND10;
         bnd21        <= ebsd_pkg::RST_BND21;
         bnd32        <= ebsd_pkg::RST_BND32;
         key          <= 8'h00;
         unlock       <= 1'b0;
         micro        <= 1'b0;
         strobe_style <= 1'b0;
         clk_set      <= 1'b0;
         strap_done   <= 1'b0;
         PRDATA       <= 32'h0;
      end else begin
         gbc          <= next_gbc;
         sbc          <= next_sbc;
         route0       <= next_route0;
         route1       <= next_route1;
         route2       <= next_route2;
         bnd10        <= next_bnd10;
         bnd21        <= next_bnd21;
         bnd32        <= next_bnd32;
         key          <= next_key;
         unlock       <= next_unlock;
         micro        <= next_micro;
         strobe_style <= next_strobe_style;
         clk_set      <= next_clk_set;
         strap_done   <= 1'b1;
         if (PSEL && !PENABLE) begin
            PRDATA <= rd_val;
         end
      end
   end

   // ----------------------------------------------------------------
   // space decode
   // ----------------------------------------------------------------
   logic [7:0] idx;
   logic       dec_hit;
   logic [1:0] dec_space;
   always_comb begin
      idx       = CPU_ADDR[25:18];
      dec_hit   = CPU_ADDR[31:26] == {6{CPU_ADDR[25]}};
      dec_space = 2'd0;
      if (idx >= bnd10) begin
         dec_space = 2'd0;
      end else if (idx >= bnd21) begin
         dec_space = 2'd1;
      end else if (idx >= bnd32) begin
         dec_space = 2'd2;
      end else if (idx >= ebsd_pkg::SPACE3_BASE) begin
         dec_space = 2'd3;
      end else begin
         dec_hit = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // bus sequencer
   // ----------------------------------------------------------------
   ebsd_pkg::ebsd_state_e st, next_st;
   logic [2:0]  beat, next_beat, last, next_last;
   logic [1:0]  space, next_space, swid, next_swid;
   logic        wr, next_wr, muxed, next_muxed;
   logic        seen, next_seen, next_miss;
   logic [25:0] base, next_base;
   logic [23:0] cur_a, next_cur_a;
   logic [63:0] wbuf, next_wbuf, next_rbuf;
   logic [3:0]  sel_n, next_sel_n;
   logic [6:0]  nb;
   logic [63:0] din;

   assign nb       = bits_of(swid);
   assign CPU_DONE = (st == ebsd_pkg::ST_DONE);
   assign status   = {space, ~sel_n[space], st != ebsd_pkg::ST_IDLE};

   always_comb begin
      next_st    = st;
      next_beat  = beat;
      next_last  = last;
      next_space = space;
      next_swid  = swid;
      next_wr    = wr;
      next_muxed = muxed;
      next_seen  = seen;
      next_miss  = CPU_MISS;
      next_base  = base;
      next_cur_a = cur_a;
      next_wbuf  = wbuf;
      next_rbuf  = CPU_RDATA;
      next_sel_n = sel_n;
      din        = muxed ? {48'h0, a_s2} : {32'h0, d_s2};
      unique case (st)
         ebsd_pkg::ST_IDLE: begin
            if (CPU_REQ) begin
               next_miss  = ~dec_hit;
               next_space = dec_space;
               next_swid  = sbc[dec_space][1:0];
               next_muxed = sbc[dec_space][ebsd_pkg::MUX_BIT] |
                            gbc[ebsd_pkg::MUX_BIT];
               next_wr    = CPU_WRITE;
               next_base  = CPU_ADDR[25:0];
               next_wbuf  = CPU_WDATA;
               next_rbuf  = 64'h0;
               next_beat  = 3'd0;
               // index of the last beat in a 64-bit word
               next_last  = 3'(7'd63 / bits_of(next_swid));
               next_st    = dec_hit ? ebsd_pkg::ST_LAUNCH
                                    : ebsd_pkg::ST_DONE;
            end
         end
         ebsd_pkg::ST_LAUNCH: begin
            if (bclk_rise) begin
               next_cur_a = base[23:0];
               next_sel_n = ~(4'h1 << space);
               next_seen  = 1'b1;
               next_st    = ebsd_pkg::ST_ADDR;
            end
         end
         ebsd_pkg::ST_ADDR: begin
            if (bclk_rise) begin
               next_st = ebsd_pkg::ST_STROBE;
            end
         end
         ebsd_pkg::ST_STROBE: begin
            if (bclk_rise) begin
               // newest beat enters at the top, so the word
               // ends up in order after the last beat
               next_rbuf = (CPU_RDATA >> nb) |
                  ((din & {32'h0, mask_of(swid)}) << (7'd64 - nb));
               next_wbuf  = wbuf >> nb;
               next_beat  = beat + 3'd1;
               next_cur_a = cur_a + 24'(nb >> 3);
               next_st    = (beat == last) ? ebsd_pkg::ST_DONE
                                           : ebsd_pkg::ST_ADDR;
            end
         end
         ebsd_pkg::ST_DONE: begin
            next_st = ebsd_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         st        <= ebsd_pkg::ST_IDLE;
         beat      <= 3'd0;
         last      <= 3'd0;
         space     <= 2'd0;
         swid      <= 2'd0;
         wr        <= 1'b0;
         muxed     <= 1'b0;
         seen      <= 1'b0;
         CPU_MISS  <= 1'b0;
         base      <= 26'h0;
         cur_a     <= 24'h0;
         wbuf      <= 64'h0;
         CPU_RDATA <= 64'h0;
         sel_n     <= 4'hF;
      end else begin
         st        <= next_st;
         beat      <= next_beat;
         last      <= next_last;
         space     <= next_space;
         swid      <= next_swid;
         wr        <= next_wr;
         muxed     <= next_muxed;
         seen      <= next_seen;
         CPU_MISS  <= next_miss;
         base      <= next_base;
         cur_a     <= next_cur_a;
         wbuf      <= next_wbuf;
         CPU_RDATA <= next_rbuf;
         sel_n     <= next_sel_n;
      end
   end

   // ----------------------------------------------------------------
   // pin assembly from registered bus state
   // ----------------------------------------------------------------
   logic strobe, byte2_mode, all_mux;
   logic [31:0] beat_d;
   assign strobe     = (st == ebsd_pkg::ST_STROBE);
   assign all_mux    = gbc[ebsd_pkg::MUX_BIT];
   assign byte2_mode = strobe_style & (gbc[1:0] == ebsd_pkg::W32);
   // lanes above the space width carry zeros
   assign beat_d     = wbuf[31:0] & mask_of(swid);
   assign RD_N       = ~(strobe & ~wr);
   assign WR_N       = ~(strobe & wr);
   assign ALE        = muxed & (st == ebsd_pkg::ST_ADDR);
   assign ALT_SEL_OUT = sel_n;
   assign ALT_SEL_OE  = route1;

   always_comb begin
      A_OUT = cur_a;
      A_OE  = {24{seen}};
      if (all_mux) begin
         A_OE[19:16] = 4'h0;
      end
      if (muxed && strobe) begin
         if (swid == ebsd_pkg::W8) begin
            A_OUT[7:0] = beat_d[7:0];
         end else begin
            A_OUT[15:0] = beat_d[15:0];
         end
         if (!wr) begin
            A_OE[15:0] = 16'h0;
         end
      end
      for (int i = 0; i < 4; i++) begin
         if (route0[3 - i]) begin
            A_OUT[20 + i] = sel_n[3 - i];
            A_OE[20 + i]  = 1'b1;
         end
      end
      D_OUT = beat_d;
      D_OE  = (strobe && wr && !muxed && !all_mux) ?
              mask_of(gbc[1:0]) : 32'h0;
      PORT_SEL_OUT = sel_n[3:1];
      PORT_SEL_OE  = route2;
      if (byte2_mode) begin
         PORT_SEL_OUT[2] = ~(strobe & wr & (swid == ebsd_pkg::W32));
         PORT_SEL_OE[2]  = 1'b1;
      end
   end
endmodule : ebsd_top
`default_nettype wire

// File: tb/ebsd_asserts.sv
// Purpose: port level checks for the external bus space decoder
// Assumes: straps steady after reset, BCLK never in step with CLK
// Notes:   strobes may only move within a high BCLK phase
`default_nettype none
module ebsd_asserts (
   // clock and reset
   input wire logic        CLK,
   input wire logic        RESET_N,
   // apb
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic [7:0]  PADDR,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   // straps and cpu side
   input wire logic        BOOT_MICRO_MODE,
   input wire logic        CPU_REQ,
   input wire logic [31:0] CPU_ADDR,
   input wire logic        CPU_DONE,
   // external bus
   input wire logic        BCLK,
   input wire logic [23:0] A_OE,
   input wire logic        RD_N,
   input wire logic        WR_N,
   input wire logic [2:0]  PORT_SEL_OE
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   // zero wait slave, so every access phase is answered at once
   apb_ready_a: assert property (PSEL && PENABLE |-> PREADY)
      else $error("apb access not answered");
   apb_unmapped_a: assert property (PSEL && PENABLE && PADDR > 8'h3C
      |-> PSLVERR)
      else $error("unmapped access without error");
   done_pulse_a: assert property (CPU_DONE |=> !CPU_DONE)
      else $error("done longer than one cycle");
   done_bound_a: assert property ($rose(CPU_REQ) |-> ##[1:400] CPU_DONE)
      else $error("cpu request never finished");
   sign_miss_a: assert property (CPU_REQ
      && CPU_ADDR[31:26] != {6{CPU_ADDR[25]}} |-> RD_N && WR_N)
      else $error("strobe for a bad sign extension");
   low_miss_a: assert property (CPU_REQ && CPU_ADDR[25:18] < 8'h02
      |-> RD_N && WR_N)
      else $error("strobe outside every space");
   strobe_one_a: assert property (!RD_N |-> WR_N)
      else $error("read and write strobes together");
   // a synced rise lags BCLK by a few cycles, still inside its high phase
   bclk_sync_a: assert property ($changed(RD_N) || $changed(WR_N)
      |-> $past(BCLK, 2))
      else $error("strobe moved outside bus clock rise");
   boot_sel_a: assert property ($past(RESET_N) && BOOT_MICRO_MODE
      |-> A_OE[23])
      else $error("space 0 select pin not driven");
   quiet_sel_a: assert property (!$past(RESET_N)
      |-> PORT_SEL_OE == 3'h0 && A_OE[22:20] == 3'h0)
      else $error("spaces 1 to 3 selects driven at reset");
   // main scenarios
   cover property (!RD_N);
   cover property (!WR_N);
   cover property (PSLVERR);
endmodule : ebsd_asserts
bind ebsd_top ebsd_asserts i_ebsd_asserts (.CLK(CLK), .RESET_N(RESET_N),
   .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .BOOT_MICRO_MODE(BOOT_MICRO_MODE),
   .CPU_REQ(CPU_REQ), .CPU_ADDR(CPU_ADDR), .CPU_DONE(CPU_DONE),
   .BCLK(BCLK), .A_OE(A_OE), .RD_N(RD_N), .WR_N(WR_N),
   .PORT_SEL_OE(PORT_SEL_OE));
`default_nettype wire

// File: tb/ebsd_mem.sv
// Purpose: external memory on the far side of the bus
// Assumes: separate format reads, address steady under strobe
// Notes:   released data lines toggle so stale values never match
`default_nettype none
module ebsd_mem (
   // clock
   input  wire logic        CLK,
   // bus from the device
   input  wire logic        RD_N,
   input  wire logic        WR_N,
   input  wire logic [23:0] A_OUT,
   input  wire logic [31:0] D_OUT,
   // answers
   output logic [31:0]      D_IN,
   output logic [15:0]      A_IN
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] wlast;
   initial begin
      D_IN = 32'h0;
      A_IN = 16'h0;
      wlast = 32'h0;
   end
   // read word derived from address, all lanes filled
   always @(posedge CLK) begin
      if (!RD_N) D_IN <= {~A_OUT[15:0], A_OUT[15:0]};
      else D_IN <= ~D_IN;
      A_IN <= ~A_IN;
      if (!WR_N) wlast <= D_OUT;
   end
endmodule : ebsd_mem
`default_nettype wire

// File: tb/tb.sv
// Purpose: self-checking bench for the external bus space decoder
// Assumes: microprocessor mode strap, 16-bit boot width
// Notes:   selects routed to address pins 23..20 for observation
`default_nettype none
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin err_total++; \
   $display("[ERR] %0t got %h exp %h", $time, g, x); end end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic CPU_REQ, CPU_WRITE, CPU_DONE, CPU_MISS, BCLK, RD_N, WR_N, ALE;
   logic [7:0]  PADDR;
   logic [31:0] PWDATA, PRDATA, CPU_ADDR, D_OUT, D_OE, D_IN, r, a, dmax;
   logic [63:0] CPU_WDATA, CPU_RDATA, wd;
   logic [23:0] A_OUT, A_OE;
   logic [15:0] A_IN;
   logic [3:0]  ALT_SEL_OUT, ALT_SEL_OE, sel;
   logic [2:0]  PORT_SEL_OUT, PORT_SEL_OE;
   logic [31:0] seed = 32'h54F36077;
   logic        e, b2, ale;
   int          err_total, compares, s;
   logic [1:0]  wtab [4] = '{2'h2, 2'h1, 2'h0, 2'h2};
   logic [7:0]  ra [6] = '{8'h20, 8'h24, 8'h28, 8'h14, 8'h00, 8'h34};
   logic [7:0]  rv [6] = '{8'hC0, 8'h80, 8'h40, 8'h01, 8'h01, 8'h01};
   logic [31:0] corner [6] = '{32'hFF000000, 32'hFEFC0000, 32'h01000000,
                               32'h00080000, 32'h00040000, 32'h04000000};
   // ----------------------------------------------------------------
   // design, memory and clocks
   // ----------------------------------------------------------------
   ebsd_top i_ebsd_top (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .BOOT_MICRO_MODE(1'b1), .BOOT_VECTOR_LSB(2'h1), .CPU_REQ(CPU_REQ),
      .CPU_WRITE(CPU_WRITE), .CPU_ADDR(CPU_ADDR), .CPU_WDATA(CPU_WDATA),
      .CPU_RDATA(CPU_RDATA), .CPU_DONE(CPU_DONE), .CPU_MISS(CPU_MISS),
      .BCLK(BCLK), .A_OUT(A_OUT), .A_OE(A_OE), .A_IN(A_IN), .D_OUT(D_OUT),
      .D_OE(D_OE), .D_IN(D_IN), .RD_N(RD_N), .WR_N(WR_N), .ALE(ALE),
      .ALT_SEL_OUT(ALT_SEL_OUT), .ALT_SEL_OE(ALT_SEL_OE),
      .PORT_SEL_OUT(PORT_SEL_OUT), .PORT_SEL_OE(PORT_SEL_OE));
   ebsd_mem i_ebsd_mem (.CLK(CLK), .RD_N(RD_N), .WR_N(WR_N),
      .A_OUT(A_OUT), .D_OUT(D_OUT), .D_IN(D_IN), .A_IN(A_IN));
   always #12.5 CLK = ~CLK;
   // bus clock offset so its edges never meet CLK edges
   initial begin
      BCLK = 1'b0;
      #7;
      forever #100 BCLK = ~BCLK;
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   // space index by reset boundaries, 4 for no space
   function automatic int space_of(input logic [31:0] v);
      if (v[31:26] != {6{v[25]}} || v[25:18] < 8'h02) return 4;
      if (v[25:18] >= 8'hC0) return 0;
      if (v[25:18] >= 8'h80) return 1;
      return (v[25:18] >= 8'h40) ? 2 : 3;
   endfunction : space_of
   // low beat first, address steps by the lane width
   function automatic logic [63:0] exp_rd(input logic [31:0] v,
                                          input logic [1:0]  w);
      logic [63:0] q;
      logic [15:0] p;
      int          nb;
      nb = (w == 2'h2) ? 4 : (w == 2'h1) ? 2 : 1;
      q = 64'h0;
      for (int k = 0; k < 8 / nb; k++) begin
         p = v[15:0] + 16'(k * nb);
         q = q | ((64'({~p, p}) & ((64'h1 << (8 * nb)) - 1)) << (8 * nb * k));
      end
      return q;
   endfunction : exp_rd
   task automatic apb(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= ad;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   // records byte-2 strobe, address latch and data enables on the way
   task automatic cpu(input logic w, input logic [31:0] ad,
                      input logic [63:0] d);
      @(posedge CLK);
      CPU_REQ <= 1'b1;
      CPU_WRITE <= w;
      CPU_ADDR <= ad;
      CPU_WDATA <= d;
      b2 = 1'b0;
      ale = 1'b0;
      dmax = 32'h0;
      do begin
         @(posedge CLK);
         if (WR_N === 1'b0 && PORT_SEL_OUT[2] === 1'b0) b2 = 1'b1;
         if (ALE === 1'b1) ale = 1'b1;
         dmax = dmax | D_OE;
      end while (CPU_DONE !== 1'b1);
      CPU_REQ <= 1'b0;
      @(posedge CLK);
   endtask : cpu
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   initial begin
      #400000;
      err_total++;
      wrap_up();
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      {CLK, RESET_N, PSEL, PENABLE, PWRITE, CPU_REQ, CPU_WRITE} = 7'h0;
      {PADDR, PWDATA, CPU_ADDR, CPU_WDATA} = 136'h0;
      repeat (20) @(posedge CLK);
      RESET_N <= 1'b1;
      @(posedge CLK);
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, ra[i], 32'h0);
         `CHK(r, {24'h0, rv[i]})
      end
      apb(1'b0, 8'h40, 32'h0);
      `CHK({e, r}, 33'h100000000)
      $display("reset values done");
      apb(1'b1, ebsd_pkg::OFF_GLOBAL, 32'h2);
      apb(1'b0, ebsd_pkg::OFF_GLOBAL, 32'h0);
      `CHK(r, 32'h1)
      apb(1'b1, ebsd_pkg::OFF_KEY, 32'hAA);
      apb(1'b1, ebsd_pkg::OFF_GLOBAL, 32'h2);
      apb(1'b0, ebsd_pkg::OFF_GLOBAL, 32'h0);
      `CHK(r, 32'h2)
      for (int i = 0; i < 4; i++)
         apb(1'b1, ebsd_pkg::OFF_SPACE0 + 8'(4 * i), {30'h0, wtab[i]});
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, ebsd_pkg::OFF_ROUTE2, 32'h7);
         apb(1'b0, ebsd_pkg::OFF_ROUTE2, 32'h0);
         `CHK(r, 32'(i * 7))
         apb(1'b1, ebsd_pkg::OFF_PROTECT, 32'h2);
      end
      apb(1'b1, ebsd_pkg::OFF_ROUTE0, 32'hF);
      apb(1'b1, ebsd_pkg::OFF_MODE, 32'h2);
      $display("protection done");
      sel = 4'hF;
      for (int i = 0; i < 30; i++) begin
         seed = lfsr(seed);
         a = {{6{seed[25]}}, seed[25:3], 3'h0};
         if (seed[30:29] == 2'h0) a[27] = ~a[27];
         if (i < 6) a = corner[i];
         wd = {seed, ~seed};
         s = space_of(a);
         cpu(seed[31], a, wd);
         if (s < 4) sel = 4'hF & ~(4'h8 >> s);
         `CHK(CPU_MISS, s == 4)
         `CHK(A_OUT[23:20], sel)
         `CHK(ALT_SEL_OUT, {sel[0], sel[1], sel[2], sel[3]})
         if (s < 4) `CHK(ale, 1'b0)
         if (s < 4 && !seed[31]) `CHK(CPU_RDATA, exp_rd(a, wtab[s]))
         if (s < 4 && seed[31]) `CHK(b2, wtab[s] == 2'h2)
         if (s < 4 && seed[31] && wtab[s] == 2'h2)
            `CHK(i_ebsd_mem.wlast, wd[63:32])
      end
      $display("decode done");
      apb(1'b1, ebsd_pkg::OFF_SPACE0 + 8'h8, 32'h4);
      cpu(1'b1, 32'h01000000, wd);
      `CHK({ale, dmax}, 33'h100000000)
      // fresh reset, so the global control is written only once
      RESET_N <= 1'b0;
      repeat (2) @(posedge CLK);
      RESET_N <= 1'b1;
      repeat (2) @(posedge CLK);
      apb(1'b1, ebsd_pkg::OFF_KEY, 32'hAA);
      apb(1'b1, ebsd_pkg::OFF_GLOBAL, 32'h6);
      cpu(1'b1, 32'h00100000, wd);
      `CHK({ale, dmax}, 33'h100000000)
      $display("muxed formats done");
      wrap_up();
   end
endmodule : tb
`undef CHK
`default_nettype wire
